/* File: logic/phs_pkg.sv */
// Shared constants and types of the suspend, abort and output-program command block
package phs_pkg;

    // ----------------------------------------
    // Motion kinds reported by the sequencer
    // ----------------------------------------
    typedef enum logic [2:0] {
        MK_NONE = 3'h0,
        MK_POS  = 3'h1,
        MK_REG  = 3'h2,
        MK_FJR  = 3'h3,
        MK_RJR  = 3'h4,
        MK_HOME = 3'h5,
        MK_JOG  = 3'h6
    } phs_kind_t;

    // ----------------------------------------
    // Output modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        OM_INACTIVE = 2'h0,
        OM_ACTIVE   = 2'h1,
        OM_ZONE     = 2'h2,
        OM_KEEP     = 2'h3
    } phs_omode_t;

    localparam phs_omode_t OUT_MODE_RST = OM_INACTIVE;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int LINE_DEPTH = 16;
    localparam int NAME_LEN = 5;
    localparam int NUM_OUT = 8;
    localparam int TAIL_LEN = 4;

    // ----------------------------------------
    // Characters
    // ----------------------------------------
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_O = 8'h4f;
    localparam logic [7:0] CH_K = 8'h4b;
    localparam logic [7:0] CH_N = 8'h4e;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_Z = 8'h5a;
    localparam logic [7:0] CH_KEEP = 8'h3a;
    localparam logic [7:0] CH_AXIS_DEF = 8'h31;

    // ----------------------------------------
    // Command names, right aligned
    // ----------------------------------------
    localparam logic [39:0] NM_MOVE = 40'h0000005354;
    localparam logic [39:0] NM_MOVE_ABS = 40'h0000535441;
    localparam logic [39:0] NM_MOVE_INC = 40'h0000535449;
    localparam logic [39:0] NM_REG = 40'h0000005253;
    localparam logic [39:0] NM_REG_ABS = 40'h0000525341;
    localparam logic [39:0] NM_REG_INC = 40'h0000525349;
    localparam logic [39:0] NM_FWD_JOG_REG = 40'h524a4f4750;
    localparam logic [39:0] NM_REV_JOG_REG = 40'h524a4f474e;
    localparam logic [39:0] NM_HOMING = 40'h00005a524e;
    localparam logic [39:0] NM_FWD_JOG = 40'h004a4f4750;
    localparam logic [39:0] NM_REV_JOG = 40'h004a4f474e;
    localparam logic [39:0] NM_HOLD = 40'h00484f4c44;
    localparam logic [39:0] NM_SKIP = 40'h00534b4950;
    localparam logic [39:0] NM_OUT_PROG = 40'h00504f5554;

endpackage : phs_pkg

/* File: logic/phs_line_mem.sv */
// Line buffer holding one received command line
`timescale 1ns/100ps
`default_nettype none
module phs_line_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : phs_line_mem
`default_nettype wire

/* File: logic/phs_cmd.sv */
// Serial command interpreter for suspend, abort and output-program commands
//
// How it works
// - A suspend halts the running move, unless it is a plain jog, and keeps its remainder pending.
// - A suspended positioning move resumes on a plain start command with no argument.
// - A suspended registration move resumes on a plain registration-start command.
// - A suspended jog-with-registration restarts when a jog-with-registration command is reissued.
// - A suspended homing restarts when the homing command is issued again.
// - A suspend during a plain jog stops the jog and keeps nothing pending.
// - A target set before resuming drops the remainder and moves to the new target.
// - A speed changed while suspended is applied when the move resumes.
// - An abort stops the move and discards the remaining distance.
// - The output-program command sets eight outputs from N, A, Z or colon characters.
// - Commands carry an axis prefix and end in CR; replies echo the line and end in CR LF.
`timescale 1ns/100ps
`default_nettype none
module phs_cmd
    import phs_pkg::*;
#(
    parameter logic [7:0] AXIS_CHAR = phs_pkg::CH_AXIS_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic seq_busy,
    input wire phs_pkg::phs_kind_t seq_kind,
    input wire logic target_set,
    input wire logic speed_set,
    input wire logic [phs_pkg::NUM_OUT-1:0] zone_match,
    output logic seq_hold,
    output logic seq_abort,
    output logic seq_start,
    output phs_pkg::phs_kind_t seq_start_kind,
    output logic seq_resume,
    output logic seq_new_target,
    output logic seq_speed_reload,
    output logic pend_valid,
    output logic [phs_pkg::NUM_OUT-1:0] prog_output
);
    import phs_pkg::*;

    localparam int AW = $clog2(LINE_DEPTH);
    localparam int LW = $clog2(LINE_DEPTH + TAIL_LEN);

    typedef enum logic [4:0] {
        S_RECV = 5'h01,
        S_EXEC = 5'h02,
        S_FETCH = 5'h04,
        S_LOAD = 5'h08,
        S_SEND = 5'h10
    } phs_state_t;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_upper(input logic [7:0] ch);
        return (ch >= CH_A) && (ch <= CH_Z);
    endfunction : is_upper

    function automatic phs_omode_t char_mode(input logic [7:0] ch);
        case (ch)
            CH_N: return OM_INACTIVE;
            CH_A: return OM_ACTIVE;
            CH_Z: return OM_ZONE;
            default: return OM_KEEP;
        endcase
    endfunction : char_mode

    function automatic phs_kind_t start_kind(input logic [39:0] nm);
        case (nm)
            NM_MOVE, NM_MOVE_ABS, NM_MOVE_INC: return MK_POS;
            NM_REG, NM_REG_ABS, NM_REG_INC: return MK_REG;
            NM_FWD_JOG_REG: return MK_FJR;
            NM_REV_JOG_REG: return MK_RJR;
            NM_HOMING: return MK_HOME;
            NM_FWD_JOG, NM_REV_JOG: return MK_JOG;
            default: return MK_NONE;
        endcase
    endfunction : start_kind

    function automatic logic [7:0] tail_char(input logic [1:0] i);
        case (i)
            2'h0: return CH_O;
            2'h1: return CH_K;
            2'h2: return CH_CR;
            default: return CH_LF;
        endcase
    endfunction : tail_char

    // ----------------------------------------
    // Parser state
    // ----------------------------------------
    phs_state_t state;
    logic [LW-1:0] idx;
    logic [LW-1:0] line_len;
    logic [LW-1:0] tx_idx;
    logic overflow;
    logic prefix_ok;
    logic [39:0] name;
    logic [2:0] name_cnt;
    logic name_done;
    logic has_arg;
    logic [3:0] output_program_cmd_cnt;
    logic output_program_cmd_bad;
    phs_omode_t output_program_cmd_stage [NUM_OUT];
    phs_omode_t out_mode [NUM_OUT];
    phs_kind_t pend_kind;
    logic target_dirty;
    logic speed_dirty;
    logic [7:0] rd_data;
    logic [7:0] last_sent;

    logic rx_take;
    logic rx_char;
    logic line_ok;
    logic exec_hold;
    logic exec_skip;
    logic exec_output_program_cmd;
    logic exec_start;
    logic exec_ours;
    logic tx_last;
    phs_kind_t kind_now;
    logic resume_match;

    assign rx_take = (state == S_RECV) && rx_valid;
    assign rx_char = rx_take && (rx_data != CH_CR);
    assign line_ok = (state == S_EXEC) && prefix_ok && !overflow;
    assign kind_now = start_kind(name);
    assign exec_hold = line_ok && (name == NM_HOLD) && !has_arg;
    assign exec_skip = line_ok && (name == NM_SKIP) && !has_arg;
    assign exec_output_program_cmd = line_ok && (name == NM_OUT_PROG) && (output_program_cmd_cnt == 4'(NUM_OUT)) && !output_program_cmd_bad;
    assign exec_start = line_ok && (kind_now != MK_NONE);
    assign exec_ours = exec_hold || exec_skip || exec_output_program_cmd;
    assign tx_valid = (state == S_SEND);
    assign tx_last = tx_valid && tx_ready && (tx_idx == LW'(line_len + LW'(TAIL_LEN - 1)));

    always_comb begin
        case (kind_now)
            MK_POS: resume_match = (pend_kind == MK_POS) && (name == NM_MOVE) && !has_arg;
            MK_REG: resume_match = (pend_kind == MK_REG) && (name == NM_REG) && !has_arg;
            MK_FJR, MK_RJR: resume_match = (pend_kind == MK_FJR) || (pend_kind == MK_RJR);
            MK_HOME: resume_match = (pend_kind == MK_HOME);
            default: resume_match = 1'b0;
        endcase
    end

    phs_line_mem #(.DEPTH(LINE_DEPTH), .AW(AW)) u_mem (
        .clk(clk),
        .wr_en(rx_char && (idx < LW'(LINE_DEPTH))),
        .wr_addr(idx[AW-1:0]),
        .wr_data(rx_data),
        .rd_addr(tx_idx[AW-1:0]),
        .rd_data(rd_data)
    );

    // ----------------------------------------
    // Line framing and sequencing
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_RECV;
            tx_idx <= '0;
            line_len <= '0;
        end else begin
            case (state)
                S_RECV: if (rx_take && (rx_data == CH_CR)) begin
                    state <= S_EXEC;
                    line_len <= idx;
                end
                S_EXEC: begin
                    tx_idx <= '0;
                    state <= exec_ours ? S_FETCH : S_RECV;
                end
                S_FETCH: state <= S_LOAD;
                S_LOAD: state <= S_SEND;
                S_SEND: if (tx_ready) begin
                    tx_idx <= LW'(tx_idx + 1'b1);
                    state <= tx_last ? S_RECV : S_FETCH;
                end
                default: state <= S_RECV;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data <= '0;
        end else if (state == S_LOAD) begin
            tx_data <= (tx_idx < line_len) ? rd_data : tail_char(2'(tx_idx - line_len));
        end
    end

    // Last handed-over reply character
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_sent <= '0;
        end else if (tx_valid && tx_ready) begin
            last_sent <= tx_data;
        end
    end

    // ----------------------------------------
    // Name and argument capture
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= '0;
            overflow <= 1'b0;
            prefix_ok <= 1'b0;
            name <= '0;
            name_cnt <= '0;
            name_done <= 1'b0;
            has_arg <= 1'b0;
            output_program_cmd_cnt <= '0;
            output_program_cmd_bad <= 1'b0;
            for (int i = 0; i < NUM_OUT; i++) begin
                output_program_cmd_stage[i] <= OM_KEEP;
            end
        end else if (state == S_EXEC) begin
            idx <= '0;
            overflow <= 1'b0;
            prefix_ok <= 1'b0;
            name <= '0;
            name_cnt <= '0;
            name_done <= 1'b0;
            has_arg <= 1'b0;
            output_program_cmd_cnt <= '0;
            output_program_cmd_bad <= 1'b0;
        end else if (rx_char) begin
            if (idx < LW'(LINE_DEPTH)) begin
                idx <= LW'(idx + 1'b1);
            end else begin
                overflow <= 1'b1;
            end
            if (idx == '0) begin
                prefix_ok <= (rx_data == AXIS_CHAR);
            end else if (!name_done && is_upper(rx_data) && (name != NM_OUT_PROG) && (name_cnt < 3'(NAME_LEN))) begin
                name <= {name[31:0], rx_data};
                name_cnt <= 3'(name_cnt + 1'b1);
            end else begin
                name_done <= 1'b1;
                has_arg <= 1'b1;
                if (output_program_cmd_cnt < 4'(NUM_OUT)) begin
                    output_program_cmd_stage[output_program_cmd_cnt[2:0]] <= char_mode(rx_data);
                    output_program_cmd_cnt <= 4'(output_program_cmd_cnt + 1'b1);
                    output_program_cmd_bad <= output_program_cmd_bad || ((char_mode(rx_data) == OM_KEEP) && (rx_data != CH_KEEP));
                end else begin
                    output_program_cmd_bad <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Motion commands
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_hold <= 1'b0;
            seq_abort <= 1'b0;
            seq_start <= 1'b0;
            seq_start_kind <= MK_NONE;
            seq_resume <= 1'b0;
            seq_new_target <= 1'b0;
            seq_speed_reload <= 1'b0;
        end else begin
            seq_hold <= exec_hold && seq_busy && (seq_kind != MK_JOG);
            seq_abort <= exec_skip || (exec_hold && seq_busy && (seq_kind == MK_JOG));
            seq_start <= exec_start;
            if (exec_start) begin
                seq_start_kind <= kind_now;
                seq_resume <= pend_valid && resume_match && !target_dirty;
                seq_new_target <= target_dirty;
                seq_speed_reload <= speed_dirty;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_valid <= 1'b0;
            pend_kind <= MK_NONE;
        end else if (exec_hold && seq_busy && (seq_kind != MK_JOG)) begin
            pend_valid <= 1'b1;
            pend_kind <= seq_kind;
        end else if (exec_skip || exec_start || (exec_hold && seq_busy)) begin
            pend_valid <= 1'b0;
            pend_kind <= MK_NONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_dirty <= 1'b0;
            speed_dirty <= 1'b0;
        end else begin
            if (target_set) begin
                target_dirty <= 1'b1;
            end else if (exec_start) begin
                target_dirty <= 1'b0;
            end
            if (speed_set) begin
                speed_dirty <= 1'b1;
            end else if (exec_start) begin
                speed_dirty <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Programmable outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                out_mode[i] <= OUT_MODE_RST;
            end
        end else if (exec_output_program_cmd) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (output_program_cmd_stage[i] != OM_KEEP) begin
                    out_mode[i] <= output_program_cmd_stage[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_output <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                prog_output[i] <= (out_mode[i] == OM_ACTIVE) || ((out_mode[i] == OM_ZONE) && zone_match[i]);
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_hold_keeps;
        @(posedge clk) disable iff (!rst_n)
        (exec_hold && seq_busy && seq_kind != MK_JOG) |=> (seq_hold && pend_valid && !seq_abort);
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) else $error("suspend did not keep remainder");

    property p_resume_pos;
        @(posedge clk) disable iff (!rst_n)
        (exec_start && name == NM_MOVE && !has_arg && pend_valid && pend_kind == MK_POS && !target_dirty)
            |=> (seq_start && seq_resume && seq_start_kind == MK_POS);
    endproperty
    a_resume_pos: assert property (p_resume_pos) else $error("plain start did not resume");

    property p_resume_reg;
        @(posedge clk) disable iff (!rst_n)
        (exec_start && name == NM_REG && !has_arg && pend_valid && pend_kind == MK_REG && !target_dirty)
            |=> (seq_resume && seq_start_kind == MK_REG);
    endproperty
    a_resume_reg: assert property (p_resume_reg) else $error("registration start did not resume");

    property p_restart_rjog;
        @(posedge clk) disable iff (!rst_n)
        (exec_start && (name == NM_FWD_JOG_REG || name == NM_REV_JOG_REG) && pend_valid && pend_kind == MK_FJR
            && !target_dirty)
            |=> seq_resume ##1 !pend_valid;
    endproperty
    a_restart_rjog: assert property (p_restart_rjog) else $error("jog with registration did not restart");

    property p_restart_home;
        @(posedge clk) disable iff (!rst_n)
        (exec_start && name == NM_HOMING && pend_valid && pend_kind == MK_HOME && !target_dirty) |=> seq_resume;
    endproperty
    a_restart_home: assert property (p_restart_home) else $error("homing did not restart");

    property p_jog_stop;
        @(posedge clk) disable iff (!rst_n)
        (exec_hold && seq_busy && seq_kind == MK_JOG) |=> (seq_abort && !seq_hold && !pend_valid);
    endproperty
    a_jog_stop: assert property (p_jog_stop) else $error("jog not stopped outright");

    property p_new_target;
        @(posedge clk) disable iff (!rst_n)
        (exec_start && target_dirty) |=> (seq_new_target && !seq_resume);
    endproperty
    a_new_target: assert property (p_new_target) else $error("remainder kept despite new target");

    property p_speed;
        @(posedge clk) disable iff (!rst_n)
        (exec_start && speed_dirty) |=> seq_speed_reload;
    endproperty
    a_speed: assert property (p_speed) else $error("new speed not applied");

    property p_skip;
        @(posedge clk) disable iff (!rst_n)
        exec_skip |=> (seq_abort && !pend_valid);
    endproperty
    a_skip: assert property (p_skip) else $error("abort left a remainder");

    property p_output_program_cmd;
        @(posedge clk) disable iff (!rst_n)
        (exec_output_program_cmd && output_program_cmd_stage[0] == OM_ACTIVE) |=> ##1 prog_output[0];
    endproperty
    a_output_program_cmd: assert property (p_output_program_cmd) else $error("output 0 not driven active");

    property p_frame_end;
        @(posedge clk) disable iff (!rst_n)
        tx_last |-> (tx_data == CH_LF) && (last_sent == CH_CR);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("reply not ended by CR LF");

    property p_ack;
        @(posedge clk) disable iff (!rst_n)
        exec_ours |=> ##2 tx_valid;
    endproperty
    a_ack: assert property (p_ack) else $error("accepted command got no reply");

    property p_abort_fresh;
        @(posedge clk) disable iff (!rst_n)
        (exec_start && !pend_valid) |=> (seq_start && !seq_resume);
    endproperty
    a_abort_fresh: assert property (p_abort_fresh) else $error("start resumed after abort");
endmodule : phs_cmd
`default_nettype wire

/* File: tb/phs_host_model.sv */
// Host controller model sending command lines and taking replies
`timescale 1ns/100ps
`default_nettype none
module phs_host_model (
    input wire logic clk,
    input wire logic slow,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready
);
    // ----------------------------------------
    // Line sender and reply sink
    // ----------------------------------------
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end

    // Stalls every other cycle when slow
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // Axis prefix given by caller, carriage return appended
    task automatic send_line(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= s[i];
        end
        @(posedge clk);
        rx_data <= 8'h0d;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= 8'hf2;
    endtask : send_line
endmodule : phs_host_model
`default_nettype wire

/* File: tb/phs_cmd_tb.sv */
// Self-checking bench of the suspend, abort and output-program interpreter
`timescale 1ns/100ps
`default_nettype none
module phs_cmd_tb;
    import phs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic slow = 1'b0;
    logic seq_busy = 1'b0;
    phs_kind_t seq_kind = MK_NONE;
    logic target_set = 1'b0;
    logic speed_set = 1'b0;
    logic [7:0] zone_match = 8'h00;
    logic [7:0] zprev = 8'h00;
    logic [31:0] rnd = 32'd62;
    logic rx_valid, tx_valid, tx_ready, seq_hold, seq_abort, seq_start;
    logic seq_resume, seq_new_target, seq_speed_reload, pend_valid;
    logic [7:0] rx_data, tx_data, prog_output;
    phs_kind_t seq_start_kind;
    logic [15:0] expq[$];
    int n_fail = 0;
    int compares = 0;

    always #5 clk = ~clk;

    phs_cmd i_dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .seq_busy(seq_busy), .seq_kind(seq_kind),
        .target_set(target_set), .speed_set(speed_set), .zone_match(zone_match), .seq_hold(seq_hold),
        .seq_abort(seq_abort), .seq_start(seq_start), .seq_start_kind(seq_start_kind),
        .seq_resume(seq_resume), .seq_new_target(seq_new_target), .seq_speed_reload(seq_speed_reload),
        .pend_valid(pend_valid), .prog_output(prog_output));

    phs_host_model i_host (.clk(clk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_ready(tx_ready));

    // ----------------------------------------
    // Random zone inputs
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    always @(posedge clk) begin
        rnd <= xs(rnd);
        zone_match <= rnd[7:0];
        zprev <= zone_match;
    end

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic take(input logic [15:0] got);
        if (expq.size() == 0)
            chk("unexpected output", 16'hffff, got);
        else
            chk("output event", expq.pop_front(), got);
    endtask : take

    // Watcher of sequencer pulses and reply characters
    always @(negedge clk) begin
        if (rst_n) begin
            if (seq_hold) take(16'h0200);
            if (seq_abort) take(16'h0300);
            if (seq_start) take({5'h08, seq_resume, seq_new_target, seq_speed_reload, 5'h00, seq_start_kind});
            if (tx_valid && tx_ready) take({8'h01, tx_data});
        end
    end

    function automatic logic [15:0] ev(input phs_kind_t k, input logic r, input logic t, input logic s);
        return {5'h08, r, t, s, 5'h00, k};
    endfunction : ev

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic drain();
        int k;
        k = 0;
        while (expq.size() != 0 && k < 300) begin
            @(posedge clk);
            k++;
        end
        if (expq.size() != 0) begin
            n_fail++;
            $display("MISMATCH queue expected empty seen %0d", expq.size());
            print_verdict();
        end
        repeat (6) @(posedge clk);
    endtask : drain

    task automatic line(input string s, input bit reply);
        if (reply) begin
            for (int i = 0; i < s.len(); i++) expq.push_back({8'h01, s[i]});
            expq.push_back({8'h01, CH_O});
            expq.push_back({8'h01, CH_K});
            expq.push_back({8'h01, CH_CR});
            expq.push_back({8'h01, CH_LF});
        end
        i_host.send_line(s);
        drain();
    endtask : line

    task automatic motion(input logic b, input phs_kind_t k);
        @(posedge clk);
        seq_busy <= b;
        seq_kind <= k;
    endtask : motion

    task automatic pulse(input logic t, input logic s);
        @(posedge clk);
        target_set <= t;
        speed_set <= s;
        @(posedge clk);
        target_set <= 1'b0;
        speed_set <= 1'b0;
    endtask : pulse

    task automatic hold_pos();
        motion(1'b1, MK_POS);
        expq.push_back(16'h0200);
        line("1HOLD", 1'b1);
    endtask : hold_pos

    initial begin
        phs_kind_t held[4] = '{MK_POS, MK_REG, MK_FJR, MK_HOME};
        string resn[4] = '{"1ST", "1RS", "1RJOGP", "1ZRN"};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset outputs", 16'h0000, {7'h00, pend_valid, prog_output});
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            motion(1'b1, held[i]);
            expq.push_back(16'h0200);
            line("1HOLD", 1'b1);
            chk("pend_valid", 16'h0001, {15'h0, pend_valid});
            motion(1'b0, MK_NONE);
            expq.push_back(ev(held[i], 1'b1, 1'b0, 1'b0));
            line(resn[i], 1'b0);
            chk("pend_valid", 16'h0000, {15'h0, pend_valid});
            $display("test resume %s done", resn[i]);
        end
        motion(1'b1, MK_JOG);
        expq.push_back(16'h0300);
        line("1HOLD", 1'b1);
        chk("pend_valid", 16'h0000, {15'h0, pend_valid});
        motion(1'b0, MK_NONE);
        expq.push_back(ev(MK_POS, 1'b0, 1'b0, 1'b0));
        line("1ST", 1'b0);
        $display("test jog suspend done");
        hold_pos();
        pulse(1'b1, 1'b1);
        motion(1'b0, MK_NONE);
        expq.push_back(ev(MK_POS, 1'b0, 1'b1, 1'b1));
        line("1ST", 1'b0);
        hold_pos();
        pulse(1'b0, 1'b1);
        expq.push_back(ev(MK_POS, 1'b1, 1'b0, 1'b1));
        line("1ST", 1'b0);
        $display("test target and speed done");
        hold_pos();
        line("2HOLD", 1'b0);
        line("1HOLDX", 1'b0);
        expq.push_back(16'h0300);
        line("1SKIP", 1'b1);
        chk("pend_valid", 16'h0000, {15'h0, pend_valid});
        motion(1'b0, MK_NONE);
        expq.push_back(ev(MK_POS, 1'b0, 1'b0, 1'b0));
        line("1ST", 1'b0);
        $display("test abort done");
        hold_pos();
        expq.push_back(ev(MK_POS, 1'b0, 1'b0, 1'b0));
        line("1STA5", 1'b0);
        expq.push_back(ev(MK_JOG, 1'b0, 1'b0, 1'b0));
        line("1JOGN", 1'b0);
        $display("test start variants done");
        slow <= 1'b1;
        line("1POUTAAAAAAAA", 1'b1);
        chk("prog_output", 16'h00ff, {8'h00, prog_output});
        line("1POUTN:ZAN:ZA", 1'b1);
        repeat (8) begin
            @(negedge clk);
            chk("prog_output", {8'h00, 8'haa | (zprev & 8'h44)}, {8'h00, prog_output});
        end
        line("1POUTNAX", 1'b0);
        chk("prog_output", 16'h00aa, {8'h00, prog_output & 8'hbb});
        $display("test output program done");
        print_verdict();
    end
endmodule : phs_cmd_tb
`default_nettype wire
